// File: core/supply_fault_lockout.sv
`timescale 1ns/10ps
`include "supply_fault_consts.svh"
// Overview of operation
// - Overvoltage with select 0 keeps outputs; its flag is not latched.
// - Overvoltage with select 1 locks out all drivers to high impedance.
// - After overvoltage the stored state returns with no host action.
// - Undervoltage locks out all drivers to high impedance, unlatched.
// - After undervoltage the stored bridge state resumes automatically.
// - Latched faults clear on a reset request frame, wake toggle or reset.
// - A driver fault zeroes its stored bits until cleared and resent.
module supply_fault_lockout
  import supply_fault_pkg::*;
#(
  parameter int N = `NUM_BRIDGES
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic ce,
  input wire logic overvoltage_pin,
  input wire logic undervoltage_pin,
  input wire logic wake_enable_pin,
  input wire logic overvoltage_lockout_select,
  input wire logic frame_valid,
  input wire logic status_reset_request,
  input wire logic [N-1:0] frame_half_bridge_enable,
  input wire logic [N-1:0] frame_half_bridge_config,
  input wire logic [N-1:0] driver_fault,
  output logic [N-1:0] drive_enable,
  output logic [N-1:0] drive_high,
  output logic [N-1:0] drive_oe,
  output logic [N-1:0] half_bridge_enable,
  output logic [N-1:0] half_bridge_config,
  output logic [N-1:0] fault_latched,
  output logic overvoltage_flag,
  output logic undervoltage_flag,
  output logic lockout
);
  logic ov_s;
  logic uv_s;
  logic wake_s;
  logic wake_d;
  logic [1:0] wake_settle;
  logic wake_toggle;
  logic clear_req;
  logic lock_now;
  supply_state_e supply_state;
  supply_state_e next_supply_state;

  pin_sync #(.WIDTH(3)) u_sync (
    .mclk(mclk),
    .rst(rst),
    .ce(ce),
    .d({overvoltage_pin, undervoltage_pin, wake_enable_pin}),
    .q({ov_s, uv_s, wake_s})
  );

  always_ff @(posedge mclk) begin
    if (rst) begin
      wake_d <= 1'b0;
    end else if (ce) begin
      wake_d <= wake_s;
    end
  end

  // The synchroniser restarts at zero, so a wake pin resting high would look
  // like a toggle just after reset; toggles count only once it has settled.
  always_ff @(posedge mclk) begin
    if (rst) begin
      wake_settle <= 2'h0;
    end else if (ce && (wake_settle != `WAKE_SETTLE)) begin
      wake_settle <= wake_settle + 2'h1;
    end
  end

  assign wake_toggle = (wake_settle == `WAKE_SETTLE) && (wake_s != wake_d);

  // Power-on reset is rst itself; the other two sources are combined here.
  assign clear_req = (frame_valid && status_reset_request) ||
                     wake_toggle;

  // Undervoltage takes precedence since the supply cannot be both.
  always_comb begin
    if (uv_s) begin
      next_supply_state = supply_under;
    end else if (ov_s && overvoltage_lockout_select) begin
      next_supply_state = supply_over;
    end else begin
      next_supply_state = supply_ok;
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      supply_state <= supply_ok;
      overvoltage_flag <= 1'b0;
      undervoltage_flag <= 1'b0;
      lockout <= 1'b0;
    end else if (ce) begin
      supply_state <= next_supply_state;
      overvoltage_flag <= ov_s;
      undervoltage_flag <= uv_s;
      lockout <= (next_supply_state != supply_ok);
    end
  end

  assign lock_now = (next_supply_state != supply_ok);

  genvar i;
  generate
    for (i = 0; i < N; i++) begin : g_bridge
      // A fault arriving with a clear keeps its latch; the set wins.
      always_ff @(posedge mclk) begin
        if (rst) begin
          fault_latched[i] <= 1'b0;
        end else if (ce) begin
          if (driver_fault[i]) begin
            fault_latched[i] <= 1'b1;
          end else if (clear_req) begin
            fault_latched[i] <= 1'b0;
          end
        end
      end

      // The lockout never touches these bits so recovery is automatic.
      always_ff @(posedge mclk) begin
        if (rst) begin
          half_bridge_enable[i] <= 1'(`ENA_RESET >> i);
          half_bridge_config[i] <= 1'(`CFG_RESET >> i);
        end else if (ce) begin
          if (driver_fault[i] || fault_latched[i]) begin
            half_bridge_enable[i] <= 1'b0;
            half_bridge_config[i] <= 1'b0;
          end else if (frame_valid) begin
            half_bridge_enable[i] <= frame_half_bridge_enable[i];
            half_bridge_config[i] <= frame_half_bridge_config[i];
          end
        end
      end

      always_ff @(posedge mclk) begin
        if (rst) begin
          drive_enable[i] <= 1'b0;
          drive_high[i] <= 1'b0;
          drive_oe[i] <= 1'b0;
        end else if (ce) begin
          if (lock_now || driver_fault[i] || fault_latched[i]) begin
            drive_enable[i] <= 1'b0;
            drive_high[i] <= 1'b0;
            drive_oe[i] <= 1'b0;
          end else begin
            drive_enable[i] <= half_bridge_enable[i];
            drive_high[i] <= half_bridge_config[i];
            drive_oe[i] <= half_bridge_enable[i];
          end
        end
      end
    end
  endgenerate

  property p_uv_hiz;
    @(posedge mclk) disable iff (rst)
      (ce && uv_s) |=> (drive_oe == '0);
  endproperty
  a_uv_hiz: assert property (p_uv_hiz)
    else $error("undervoltage not high z");

  property p_uv_lock;
    @(posedge mclk) disable iff (rst)
      (ce && uv_s) |=> (lockout && undervoltage_flag);
  endproperty
  a_uv_lock: assert property (p_uv_lock)
    else $error("undervoltage not reported");

  property p_ov_hiz;
    @(posedge mclk) disable iff (rst)
      (ce && ov_s && overvoltage_lockout_select) |=> (drive_oe == '0);
  endproperty
  a_ov_hiz: assert property (p_ov_hiz)
    else $error("overvoltage not high z");

  property p_ov_pass;
    @(posedge mclk) disable iff (rst)
      (ce && ov_s && !uv_s && !overvoltage_lockout_select &&
       driver_fault == '0 && fault_latched == '0)
      |=> (drive_oe == $past(half_bridge_enable));
  endproperty
  a_ov_pass: assert property (p_ov_pass)
    else $error("overvoltage with select 0 changed outputs");

  property p_recover;
    @(posedge mclk) disable iff (rst)
      (ce && !lock_now && driver_fault == '0 && fault_latched == '0)
      |=> (drive_enable == $past(half_bridge_enable));
  endproperty
  a_recover: assert property (p_recover)
    else $error("no auto recovery");

  property p_keep_store;
    @(posedge mclk) disable iff (rst)
      (ce && lock_now && !frame_valid && driver_fault == '0 &&
       fault_latched == '0) |=> $stable(half_bridge_enable);
  endproperty
  a_keep_store: assert property (p_keep_store)
    else $error("store changed");

  property p_uv_flag;
    @(posedge mclk) disable iff (rst)
      ce |=> (undervoltage_flag == $past(uv_s));
  endproperty
  a_uv_flag: assert property (p_uv_flag)
    else $error("uv flag latched");

  property p_fault_zero;
    @(posedge mclk) disable iff (rst)
      (ce && driver_fault != '0) |=>
        ((half_bridge_enable & $past(driver_fault)) == '0);
  endproperty
  a_fault_zero: assert property (p_fault_zero)
    else $error("fault kept enable");

  property p_fault_off;
    @(posedge mclk) disable iff (rst)
      (ce && driver_fault != '0) |=>
        ((drive_enable & $past(driver_fault)) == '0);
  endproperty
  a_fault_off: assert property (p_fault_off)
    else $error("fault kept driver on");

  property p_clear;
    @(posedge mclk) disable iff (rst)
      (ce && clear_req && driver_fault == '0) |=> (fault_latched == '0);
  endproperty
  a_clear: assert property (p_clear)
    else $error("fault not cleared");

  c_uv: cover property (@(posedge mclk) disable iff (rst)
    (supply_state == supply_under) ##1 (supply_state == supply_ok));
  c_ov: cover property (@(posedge mclk) disable iff (rst)
    (supply_state == supply_over) ##1 (supply_state == supply_ok));
  c_clr: cover property (@(posedge mclk) disable iff (rst)
    (fault_latched != '0) ##1 (fault_latched == '0));
  c_wake: cover property (@(posedge mclk) disable iff (rst) wake_toggle);
endmodule

// File: core/supply_fault_consts.svh
`ifndef SUPPLY_FAULT_CONSTS_SVH
`define SUPPLY_FAULT_CONSTS_SVH
`define NUM_BRIDGES 6
`define CFG_RESET 6'h00
`define ENA_RESET 6'h00
`define WAKE_SETTLE 2'h3
`endif

// File: core/supply_fault_pkg.sv
package supply_fault_pkg;
  typedef enum logic [1:0] {
    supply_ok = 2'b00,
    supply_over = 2'b01,
    supply_under = 2'b10
  } supply_state_e;
endpackage

// File: core/pin_sync.sv
`timescale 1ns/10ps
module pin_sync #(
  parameter int WIDTH = 1
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic ce,
  input wire logic [WIDTH-1:0] d,
  output logic [WIDTH-1:0] q
);
  logic [WIDTH-1:0] stage1;
  // The first stage feeds only the second, to contain metastability.
  always_ff @(posedge mclk) begin
    if (rst) begin
      stage1 <= '0;
      q <= '0;
    end else if (ce) begin
      stage1 <= d;
      q <= stage1;
    end
  end
endmodule

// File: tb/host_model.sv
`timescale 1ns/10ps
module host_model (
  input wire logic mclk,
  output logic frame_valid,
  output logic status_reset_request,
  output logic [5:0] hb_en,
  output logic [5:0] hb_cfg
);
  initial begin
    {frame_valid, status_reset_request, hb_en, hb_cfg} = '0;
  end
  // Payload is inverted after the frame so that stale bits never pass.
  task automatic send(input logic [5:0] e, c, input logic s);
    @(posedge mclk);
    frame_valid <= 1'b1;
    status_reset_request <= s;
    hb_en <= e;
    hb_cfg <= c;
    @(posedge mclk);
    frame_valid <= 1'b0;
    hb_en <= ~e;
    hb_cfg <= ~c;
  endtask
endmodule

// File: tb/tb_supply_fault_lockout.sv
`timescale 1ns/10ps
module tb_supply_fault_lockout;
  logic mclk = 1'b0, rst = 1'b1, ce = 1'b1, ov = 1'b0, uv = 1'b0;
  logic wake = 1'b0, sel = 1'b0, fv, reset_req, ovf, uvf, lk;
  logic [5:0] fe, fc, flt = 6'h00, doe, de, dh, hbe, hbc, fl;
  int failures = 0, n_tests = 0, cyc = 0;
  initial forever #2 mclk = ~mclk;
  host_model host (.mclk(mclk), .frame_valid(fv),
    .status_reset_request(reset_req), .hb_en(fe), .hb_cfg(fc));
  supply_fault_lockout DUT (.mclk(mclk), .rst(rst), .ce(ce),
    .overvoltage_pin(ov), .undervoltage_pin(uv),
    .wake_enable_pin(wake), .overvoltage_lockout_select(sel),
    .frame_valid(fv), .status_reset_request(reset_req),
    .frame_half_bridge_enable(fe), .frame_half_bridge_config(fc),
    .driver_fault(flt), .drive_enable(de), .drive_high(dh),
    .drive_oe(doe), .half_bridge_enable(hbe),
    .half_bridge_config(hbc), .fault_latched(fl),
    .overvoltage_flag(ovf), .undervoltage_flag(uvf), .lockout(lk));
  task automatic chk(string n, logic [5:0] e, logic [5:0] g);
    n_tests++;
    if (g !== e) begin
      failures++;
      $display("[ERR] %s exp %h got %h", n, e, g);
    end
  endtask
  task automatic tick(int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask
  task automatic summarize();
    if (failures == 0 && n_tests > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // Pins need two sync stages plus the output register.
  task automatic t_ov(logic s, logic [5:0] oe);
    @(posedge mclk);
    sel <= s;
    ov <= 1'b1;
    tick(4);
    chk("drive_oe", oe, doe);
    chk("drive_high", s ? 6'h00 : 6'h15, dh);
    chk("ov_flag", 6'h01, {5'h0, ovf});
    chk("lockout", {5'h0, s}, {5'h0, lk});
    chk("hb_enable", 6'h3f, hbe);
    @(posedge mclk);
    ov <= 1'b0;
    tick(4);
    chk("drive_oe", 6'h3f, doe);
    chk("drive_high", 6'h15, dh);
    chk("ov_flag", 6'h00, {5'h0, ovf});
    chk("lockout", 6'h00, {5'h0, lk});
  endtask
  task automatic t_uv();
    @(posedge mclk);
    uv <= 1'b1;
    tick(4);
    chk("drive_oe", 6'h00, doe);
    chk("drive_enable", 6'h00, de);
    chk("drive_high", 6'h00, dh);
    chk("uv_flag", 6'h01, {5'h0, uvf});
    chk("lockout", 6'h01, {5'h0, lk});
    chk("hb_config", 6'h15, hbc);
    @(posedge mclk);
    uv <= 1'b0;
    tick(4);
    chk("drive_oe", 6'h3f, doe);
    chk("drive_high", 6'h15, dh);
    chk("uv_flag", 6'h00, {5'h0, uvf});
  endtask
  // With the clock enable low even the pin synchroniser must stand still.
  task automatic t_ce();
    @(posedge mclk);
    ce <= 1'b0;
    uv <= 1'b1;
    tick(5);
    chk("drive_oe", 6'h3f, doe);
    chk("uv_flag", 6'h00, {5'h0, uvf});
    @(posedge mclk);
    ce <= 1'b1;
    tick(4);
    chk("drive_oe", 6'h00, doe);
    @(posedge mclk);
    uv <= 1'b0;
    tick(4);
    chk("drive_oe", 6'h3f, doe);
  endtask
  task automatic t_fault(logic wk);
    @(posedge mclk);
    flt <= 6'h01;
    @(posedge mclk);
    flt <= 6'h00;
    tick(2);
    chk("fault", 6'h01, fl);
    chk("hb_enable", 6'h3e, hbe);
    chk("hb_config", 6'h14, hbc);
    chk("drive_enable", 6'h3e, de);
    if (wk) begin
      @(posedge mclk);
      wake <= ~wake;
      tick(5);
    end else begin
      host.send(6'h3f, 6'h15, 1'b1);
      tick(1);
    end
    chk("fault", 6'h00, fl);
    chk("hb_enable", 6'h3e, hbe);
    host.send(6'h3f, 6'h15, 1'b0);
    tick(1);
    chk("hb_enable", 6'h3f, hbe);
    chk("drive_enable", 6'h3f, de);
  endtask
  // The wake pin rests high here, which must not read as a toggle.
  task automatic t_por();
    @(posedge mclk);
    flt <= 6'h20;
    @(posedge mclk);
    flt <= 6'h00;
    rst <= 1'b1;
    @(posedge mclk);
    rst <= 1'b0;
    tick(0);
    chk("fault", 6'h00, fl);
    chk("hb_enable", 6'h00, hbe);
    @(posedge mclk);
    flt <= 6'h01;
    @(posedge mclk);
    flt <= 6'h00;
    tick(4);
    chk("fault", 6'h01, fl);
  endtask
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (cyc == 1000) begin
      failures++;
      summarize();
    end
  end
  initial begin
    repeat (16) @(posedge mclk);
    rst <= 1'b0;
    host.send(6'h3f, 6'h15, 1'b0);
    tick(2);
    chk("drive_oe", 6'h3f, doe);
    chk("drive_high", 6'h15, dh);
    t_ov(1'b0, 6'h3f);
    t_ov(1'b1, 6'h00);
    t_uv();
    t_ce();
    t_fault(1'b0);
    t_fault(1'b1);
    t_por();
    summarize();
  end
endmodule
